//--- hdl/gms_mode_seq.v
// Generator-set mode sequencer top level
`timescale 1ns/1ps
`default_nettype none
`include "gms_timing_map.vh"
module gms_mode_seq #(
    parameter NUM_REQ  = `GMS_NUM_REQ,
    parameter ALARM_W  = `GMS_ALARM_W,
    parameter RET_MS   = `GMS_RETURN_DLY_MS,
    parameter COOL_MS  = `GMS_COOL_DLY_MS,
    parameter TICK_DIV = `GMS_TICK_DIV
) (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst,
    // Front-panel buttons and digital inputs
    input  wire               btn_stop,
    input  wire               btn_manual,
    input  wire               btn_auto,
    input  wire               btn_start,
    input  wire               btn_transfer,
    input  wire               btn_open,
    input  wire               din_transfer,
    input  wire               din_open,
    input  wire               din_on_load,
    // Start requests, local and multiset_comms_link
    input  wire [NUM_REQ-1:0] start_req,
    input  wire               multiset_comms_link_req,
    // Engine and external functions
    input  wire               engine_running,
    input  wire               gen_available,
    input  wire               in_sync,
    input  wire               ramp_done,
    input  wire [ALARM_W-1:0] alarm_cond,
    // Outputs to plant
    output reg                run_cmd_ff,
    output reg                close_gen_ff,
    output reg                sync_req_ff,
    output reg                ramp_req_ff,
    output reg  [ALARM_W-1:0] alarm_latch_ff,
    output reg  [1:0]         mode_ff,
    // Register port
    input  wire [3:0]         reg_addr,
    input  wire [31:0]        reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [31:0]        reg_rdata_ff,
    output wire               irq
);
    localparam [1:0] MODE_STOP = 2'b00;
    localparam [1:0] MODE_MAN  = 2'b01;
    localparam [1:0] MODE_AUTO = 2'b10;

    localparam [2:0] ST_REST   = 3'd0;
    localparam [2:0] ST_RUN    = 3'd1;
    localparam [2:0] ST_SYNC   = 3'd2;
    localparam [2:0] ST_ONLOAD = 3'd3;
    localparam [2:0] ST_RETDLY = 3'd4;
    localparam [2:0] ST_RAMP   = 3'd5;
    localparam [2:0] ST_COOL   = 3'd6;

    localparam NPIN = 9 + NUM_REQ + 1 + 4 + ALARM_W;
    localparam integer SUB_MS = `GMS_SUB_PER_MS;

    // All pin inputs through the synchroniser
    wire [NPIN-1:0] pins_raw;
    wire [NPIN-1:0] pins;
    assign pins_raw = {alarm_cond, ramp_done, in_sync, gen_available, engine_running,
                       multiset_comms_link_req, start_req, din_on_load, din_open,
                       din_transfer, btn_open, btn_transfer, btn_start, btn_auto,
                       btn_manual, btn_stop};
    gms_pin_sync #(.W(NPIN)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (pins_raw),
        .level_ff (pins)
    );
    wire [ALARM_W-1:0] s_alarm = pins[NPIN-1 -: ALARM_W];
    wire s_ramp    = pins[NUM_REQ + 13];
    wire s_sync    = pins[NUM_REQ + 12];
    wire s_avail   = pins[NUM_REQ + 11];
    wire s_running = pins[NUM_REQ + 10];
    wire s_any_req = |pins[NUM_REQ + 9 : 9];
    wire s_on_load = pins[8];
    wire [7:0] s_btn = pins[7:0];

    // Rising-edge detection on buttons
    reg  [7:0] btn_prev_ff;
    wire [7:0] btn_rise = s_btn & ~btn_prev_ff;
    wire p_stop   = btn_rise[0];
    wire p_man    = btn_rise[1] & ~p_stop;
    wire p_auto   = btn_rise[2] & ~p_stop & ~btn_rise[1];
    wire p_start  = btn_rise[3];
    wire p_xfer   = btn_rise[4] | btn_rise[6];
    wire p_open   = btn_rise[5] | btn_rise[7];

    // Registers
    reg [2:0]                state_ff;
    reg [2:0]                nxt_state;
    reg [`GMS_CNT_W-1:0]     tmr_ff;
    reg [`GMS_CNT_W-1:0]     ret_ms_ff;
    reg [`GMS_CNT_W-1:0]     cool_ms_ff;
    reg [`GMS_IRQ_W-1:0]     irq_stat_ff;
    reg [`GMS_IRQ_W-1:0]     irq_mask_ff;
    reg [1:0]                nxt_mode;

    // Software mode request through control register
    wire sw_wr_ctrl = reg_wr && (reg_addr == `GMS_REG_CTRL);
    wire sw_req_stop = sw_wr_ctrl & reg_wdata[0];
    wire go_stop = p_stop | sw_req_stop;
    always @* begin
        nxt_mode = mode_ff;
        if (go_stop) begin
            nxt_mode = MODE_STOP;
        end else if (p_man) begin
            nxt_mode = MODE_MAN;
        end else if (p_auto) begin
            nxt_mode = MODE_AUTO;
        end
    end
    wire mode_chg   = nxt_mode != mode_ff;
    wire enter_stop = mode_chg && (nxt_mode == MODE_STOP);

    // High in the cycle the sequencer moves into state st
    function enters;
        input [2:0] nxt;
        input [2:0] cur;
        input [2:0] st;
        begin
            enters = (nxt == st) && (cur != st);
        end
    endfunction

    // Sequencer next state
    wire timer_done = (tmr_ff == {`GMS_CNT_W{1'b0}});
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_REST: begin
                if (mode_ff == MODE_MAN && p_start) begin
                    nxt_state = ST_RUN;
                end else if (mode_ff == MODE_AUTO && s_any_req) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (mode_ff == MODE_MAN && s_running && (p_xfer || s_on_load)) begin
                    nxt_state = ST_SYNC;
                end else if (mode_ff == MODE_AUTO && s_avail) begin
                    nxt_state = ST_SYNC;
                end
                if (mode_ff == MODE_AUTO && !s_any_req) begin
                    nxt_state = ST_COOL;
                end
            end
            ST_SYNC: begin
                if (s_sync) begin
                    nxt_state = ST_ONLOAD;
                end else if (mode_ff == MODE_AUTO && !s_any_req) begin
                    nxt_state = ST_COOL;
                end
            end
            ST_ONLOAD: begin
                // On-load input release alone never opens the switch
                if (mode_ff == MODE_MAN && p_open) begin
                    nxt_state = ST_RAMP;
                end else if (mode_ff == MODE_AUTO && !s_any_req) begin
                    nxt_state = ST_RETDLY;
                end
            end
            ST_RETDLY: begin
                // A returning request keeps the load on
                if (s_any_req) begin
                    nxt_state = ST_ONLOAD;
                end else if (timer_done) begin
                    nxt_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (s_ramp) begin
                    nxt_state = (mode_ff == MODE_AUTO) ? ST_COOL : ST_RUN;
                end
            end
            ST_COOL: begin
                // A new request reuses the still running engine
                if (s_any_req) begin
                    nxt_state = ST_RUN;
                end else if (timer_done) begin
                    nxt_state = ST_REST;
                end
            end
            default: nxt_state = ST_REST;
        endcase
        // Stop/reset drops load and stops; manual-to-auto re-evaluates
        if (mode_chg && nxt_mode == MODE_STOP) begin
            nxt_state = ST_REST;
        end else if (mode_chg && nxt_mode == MODE_AUTO && state_ff != ST_REST) begin
            nxt_state = ST_RUN;
        end
    end

    // Delay timers load on state entry
    wire tmr_load = enters(nxt_state, state_ff, ST_RETDLY) ||
                    enters(nxt_state, state_ff, ST_COOL);

    // Millisecond tick divider
    // Restart on each timer load so no delay runs short of its set time
    reg [15:0] div_ff;
    reg [15:0] us_ff;
    wire       ms_tick = (div_ff == TICK_DIV[15:0] - 16'h0001) &&
                         (us_ff == SUB_MS[15:0] - 16'h0001);
    always @(posedge ref_clk) begin
        if (rst || tmr_load) begin
            div_ff <= 16'h0000;
            us_ff  <= 16'h0000;
        end else if (div_ff == TICK_DIV[15:0] - 16'h0001) begin
            div_ff <= 16'h0000;
            us_ff  <= (us_ff == SUB_MS[15:0] - 16'h0001) ? 16'h0000 : us_ff + 16'h0001;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state_ff       <= ST_REST;
            mode_ff        <= MODE_STOP;
            tmr_ff         <= {`GMS_CNT_W{1'b0}};
            btn_prev_ff    <= 8'h00;
            run_cmd_ff     <= 1'b0;
            close_gen_ff   <= 1'b0;
            sync_req_ff    <= 1'b0;
            ramp_req_ff    <= 1'b0;
            alarm_latch_ff <= {ALARM_W{1'b0}};
        end else begin
            btn_prev_ff <= s_btn;
            mode_ff     <= nxt_mode;
            state_ff    <= nxt_state;
            if (enters(nxt_state, state_ff, ST_RETDLY)) begin
                tmr_ff <= ret_ms_ff;
            end else if (enters(nxt_state, state_ff, ST_COOL)) begin
                tmr_ff <= cool_ms_ff;
            end else if (ms_tick && !timer_done) begin
                tmr_ff <= tmr_ff - {{(`GMS_CNT_W-1){1'b0}}, 1'b1};
            end
            run_cmd_ff   <= (nxt_state != ST_REST);
            close_gen_ff <= (nxt_state == ST_ONLOAD) || (nxt_state == ST_RETDLY) ||
                            (nxt_state == ST_RAMP);
            sync_req_ff  <= (nxt_state == ST_SYNC);
            ramp_req_ff  <= (nxt_state == ST_RAMP);
            // Causes stay latched until a stop entry finds them gone
            if (enter_stop) begin
                alarm_latch_ff <= s_alarm;
            end else begin
                alarm_latch_ff <= alarm_latch_ff | s_alarm;
            end
        end
    end

    // Events for interrupt status
    wire [`GMS_IRQ_W-1:0] ev;
    assign ev[`GMS_IRQ_CLOSED]  = (nxt_state == ST_ONLOAD) && (state_ff == ST_SYNC);
    assign ev[`GMS_IRQ_OPENED]  = (state_ff == ST_RAMP) && (nxt_state != ST_RAMP);
    assign ev[`GMS_IRQ_STOPPED] = enters(nxt_state, state_ff, ST_REST);
    assign ev[`GMS_IRQ_MODE]    = mode_chg;
    assign irq = |(irq_stat_ff & irq_mask_ff);

    wire rd_stat = reg_rd && (reg_addr == `GMS_REG_IRQ_STAT);
    always @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_ff  <= {`GMS_IRQ_W{1'b0}};
            irq_mask_ff  <= {`GMS_IRQ_W{1'b0}};
            ret_ms_ff    <= RET_MS;
            cool_ms_ff   <= COOL_MS;
            reg_rdata_ff <= 32'h0000_0000;
        end else begin
            // Read clears, an event in the same cycle survives
            irq_stat_ff <= (rd_stat ? {`GMS_IRQ_W{1'b0}} : irq_stat_ff) | ev;
            if (reg_wr) begin
                case (reg_addr)
                    `GMS_REG_IRQ_MASK: irq_mask_ff <= reg_wdata[`GMS_IRQ_W-1:0];
                    `GMS_REG_RET_DLY:  ret_ms_ff   <= reg_wdata;
                    `GMS_REG_COOL_DLY: cool_ms_ff  <= reg_wdata;
                    default: ;
                endcase
            end
            reg_rdata_ff <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `GMS_REG_STATUS:   reg_rdata_ff <= {24'h0000_00, run_cmd_ff, close_gen_ff,
                                                        mode_ff, 1'b0, state_ff};
                    `GMS_REG_IRQ_STAT: reg_rdata_ff <= {{(32-`GMS_IRQ_W){1'b0}}, irq_stat_ff};
                    `GMS_REG_IRQ_MASK: reg_rdata_ff <= {{(32-`GMS_IRQ_W){1'b0}}, irq_mask_ff};
                    `GMS_REG_ALARM:    reg_rdata_ff <= {{(32-ALARM_W){1'b0}}, alarm_latch_ff};
                    `GMS_REG_RET_DLY:  reg_rdata_ff <= ret_ms_ff;
                    `GMS_REG_COOL_DLY: reg_rdata_ff <= cool_ms_ff;
                    default:           reg_rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/gms_timing_map.vh
// Constants for the generator-set mode sequencer
// Summary of operation
// - Entering stop/reset clears every latched alarm whose cause is gone and keeps the rest.
// - Selecting stop/reset while the engine runs drops the load-switch close output.
// - In stop/reset the generator stays at rest and no run command is issued.
// - In manual mode a start press starts the generator and runs it off load.
// - In manual mode a transfer press requests synchronising and closes the switch only when in sync.
// - In manual mode an open press first ramps the load off, then opens the switch.
// - Digital inputs perform the same transfer and open functions as the buttons.
// - In manual mode, off load and running, the on-load input triggers synchronising and closing.
// - Dropping the on-load input does not open the switch; only an open press, stop/reset or auto ends it.
// - In auto mode any start request, including link requests, starts the set.
// - In auto mode, once the generator is available, sync is requested and the switch closes.
// - In auto mode withdrawal of the request runs a return delay, then ramp-off, then opening.
// - After coming off load in auto mode the engine cools for a set time, then stops.
`ifndef GMS_TIMING_MAP_VH
`define GMS_TIMING_MAP_VH
`define GMS_CLK_MHZ        250
`define GMS_RETURN_DLY_MS  30000
`define GMS_COOL_DLY_MS    60000
`define GMS_DBNC_US        20
`define GMS_TICK_DIV       250
`define GMS_SUB_PER_MS     4
`define GMS_CNT_W          32
`define GMS_ALARM_W        8
`define GMS_NUM_REQ        4
// Register offsets
`define GMS_REG_CTRL       4'h0
`define GMS_REG_STATUS     4'h1
`define GMS_REG_IRQ_STAT   4'h2
`define GMS_REG_IRQ_MASK   4'h3
`define GMS_REG_ALARM      4'h4
`define GMS_REG_RET_DLY    4'h5
`define GMS_REG_COOL_DLY   4'h6
// Irq bits
`define GMS_IRQ_W          4
`define GMS_IRQ_CLOSED     0
`define GMS_IRQ_OPENED     1
`define GMS_IRQ_STOPPED    2
`define GMS_IRQ_MODE       3
`endif

//--- hdl/gms_pin_sync.v
// Three-stage input synchroniser with agreement on last two stages
`timescale 1ns/1ps
`default_nettype none
module gms_pin_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         rst,
    // Pins
    input  wire [W-1:0] pin_in,
    // Synchronised level
    output reg  [W-1:0] level_ff
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer i;
    always @(posedge ref_clk) begin
        if (rst) begin
            s1_ff    <= {W{1'b0}};
            s2_ff    <= {W{1'b0}};
            s3_ff    <= {W{1'b0}};
            level_ff <= {W{1'b0}};
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    level_ff[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/gms_seq_chk.sv
// Port-level assertion checker for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module gms_seq_chk #(
    parameter NUM_REQ  = 4,
    parameter TICK_DIV = 250
) (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               rst,
    // Start requests
    input wire logic [NUM_REQ-1:0] start_req,
    input wire logic               multiset_comms_link_req,
    // Plant outputs
    input wire logic               run_cmd_ff,
    input wire logic               close_gen_ff,
    input wire logic               sync_req_ff,
    input wire logic               ramp_req_ff,
    input wire logic [1:0]         mode_ff,
    // Register port
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata_ff
);
    // Bench programs a two millisecond cool-down
    localparam int COOL_MIN = 2 * 4 * TICK_DIV;
    logic [15:0] off_cnt_ff;
    wire         any_req = (|start_req) | multiset_comms_link_req;

    // Cycles since the load switch last opened
    always_ff @(posedge ref_clk) begin
        if (rst || close_gen_ff) begin
            off_cnt_ff <= 16'h0000;
        end else if (off_cnt_ff != 16'hFFFF) begin
            off_cnt_ff <= off_cnt_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_plain_open;
        $fell(close_gen_ff) && mode_ff != 2'd0 && $stable(mode_ff);
    endsequence
    sequence s_stop_entry;
        mode_ff == 2'd0 && $past(mode_ff) != 2'd0;
    endsequence

    a_stop_drop: assert property (s_stop_entry |-> ##[0:1] (!close_gen_ff && !run_cmd_ff))
        else $error("stop entry left switch closed or engine running");
    a_stop_rest: assert property (mode_ff == 2'd0 && $past(mode_ff) == 2'd0 |-> !run_cmd_ff)
        else $error("run command issued in stop mode");
    a_close_run: assert property (close_gen_ff |-> run_cmd_ff)
        else $error("switch closed without engine run");
    a_close_sync: assert property ($rose(close_gen_ff) |-> $past(sync_req_ff))
        else $error("switch closed without synchronising");
    a_sync_running: assert property (sync_req_ff |-> run_cmd_ff && mode_ff != 2'd0)
        else $error("sync requested while stopped");
    a_ramp_open: assert property (s_plain_open |-> $past(ramp_req_ff))
        else $error("switch opened without ramp-off");
    a_req_starts: assert property ($rose(any_req) && mode_ff == 2'd2 |-> ##[1:12] run_cmd_ff)
        else $error("auto start request ignored");
    a_cool_time: assert property ($fell(run_cmd_ff) && mode_ff == 2'd2 |-> off_cnt_ff >= COOL_MIN)
        else $error("engine stopped before cool-down");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
        else $error("read data outside read slot");
endmodule

bind gms_mode_seq gms_seq_chk #(
    .NUM_REQ  (NUM_REQ),
    .TICK_DIV (TICK_DIV)
) u_chk (
    .ref_clk                 (ref_clk),
    .rst                     (rst),
    .start_req               (start_req),
    .multiset_comms_link_req (multiset_comms_link_req),
    .run_cmd_ff              (run_cmd_ff),
    .close_gen_ff            (close_gen_ff),
    .sync_req_ff             (sync_req_ff),
    .ramp_req_ff             (ramp_req_ff),
    .mode_ff                 (mode_ff),
    .reg_rd                  (reg_rd),
    .reg_rdata_ff            (reg_rdata_ff)
);
`default_nettype wire

//--- verif/gms_plant_model.sv
// Behavioural engine, synchroniser and load ramp
`timescale 1ns/1ps
`default_nettype none
module gms_plant_model #(
    parameter DLY = 40
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Commands and pace
    input  wire logic run_cmd,
    input  wire logic sync_req,
    input  wire logic ramp_req,
    input  wire logic slow,
    // Answers
    output logic      engine_running,
    output logic      gen_available,
    output logic      in_sync,
    output logic      ramp_done
);
    logic [DLY-1:0] run_sh;
    logic [DLY-1:0] sync_sh;
    logic [DLY-1:0] ramp_sh;
    wire  [7:0]     tap = slow ? 8'(DLY - 1) : 8'd2;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_sh  <= '0;
            sync_sh <= '0;
            ramp_sh <= '0;
        end else begin
            run_sh  <= {run_sh[DLY-2:0], run_cmd};
            sync_sh <= {sync_sh[DLY-2:0], sync_req & run_cmd};
            ramp_sh <= {ramp_sh[DLY-2:0], ramp_req};
        end
    end
    assign engine_running = run_sh[tap];
    assign gen_available  = engine_running;
    // Indications drop as soon as their request ends
    assign in_sync        = sync_sh[tap] & sync_req;
    assign ramp_done      = ramp_sh[tap] & ramp_req;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "gms_timing_map.vh"
module tb_top;
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  pins      = 8'h00;
    logic        on_load   = 1'b0;
    logic [3:0]  req       = 4'h0;
    logic        link_req  = 1'b0;
    logic [7:0]  alarms    = 8'h00;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        slow      = 1'b0;
    wire         run, close, sync, ramp, eng, avail, insync, rdone, irq;
    wire  [7:0]  alarm_latch;
    wire  [1:0]  mode;
    wire  [31:0] rdata;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #2 ref_clk = ~ref_clk;

    gms_mode_seq u_dut (
        .ref_clk(ref_clk), .rst(rst), .btn_stop(pins[0]), .btn_manual(pins[1]),
        .btn_auto(pins[2]), .btn_start(pins[3]), .btn_transfer(pins[4]), .btn_open(pins[5]),
        .din_transfer(pins[6]), .din_open(pins[7]), .din_on_load(on_load),
        .start_req(req), .multiset_comms_link_req(link_req), .engine_running(eng),
        .gen_available(avail), .in_sync(insync), .ramp_done(rdone), .alarm_cond(alarms),
        .run_cmd_ff(run), .close_gen_ff(close), .sync_req_ff(sync), .ramp_req_ff(ramp),
        .alarm_latch_ff(alarm_latch), .mode_ff(mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
        .irq(irq)
    );
    gms_plant_model u_plant (
        .ref_clk(ref_clk), .rst(rst), .run_cmd(run), .sync_req(sync), .ramp_req(ramp),
        .slow(slow), .engine_running(eng), .gen_available(avail), .in_sync(insync),
        .ramp_done(rdone)
    );

    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Level press held long enough to pass the pin filter
    task automatic press(input int i);
        @(posedge ref_clk);
        pins[i] <= 1'b1;
        repeat (10) @(posedge ref_clk);
        pins[i] <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
    endtask

    // Wait bounded for one of {eng, ramp, sync, close, run} to reach v
    task automatic wsig(input int s, input logic v);
        logic [4:0] sig;
        sig = {eng, ramp, sync, close, run};
        for (int n = 0; n < 8000 && sig[s] !== v; n++) begin
            @(posedge ref_clk);
            #1;
            sig = {eng, ramp, sync, close, run};
        end
        chk(32'(sig[s]), 32'(v));
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("BAD t=%0t timeout", $time);
            close_out();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(32'({run, close, mode}), 32'h0000_0000);
        rd(`GMS_REG_RET_DLY, 32'h0000_7530);
        rd(`GMS_REG_COOL_DLY, 32'h0000_EA60);
        rd(4'hF, 32'h0000_0000);
        wr(`GMS_REG_RET_DLY, 32'h0000_0001);
        wr(`GMS_REG_COOL_DLY, 32'h0000_0002);
        wr(`GMS_REG_IRQ_MASK, 32'h0000_000F);
        wr(4'hF, 32'h0000_00FF);
        rd(`GMS_REG_IRQ_MASK, 32'h0000_000F);
        @(posedge ref_clk);
        alarms <= 8'h03;
        press(1);
        chk(32'(mode), 32'h0000_0001);
        chk(32'(alarm_latch), 32'h0000_0003);
        press(3);
        wsig(0, 1'b1);
        chk(32'(close), 32'h0000_0000);
        rd(`GMS_REG_STATUS, 32'h0000_0091);
        wsig(4, 1'b1);
        press(4);
        wsig(1, 1'b1);
        chk(32'(irq), 32'h0000_0001);
        rd(`GMS_REG_IRQ_STAT, 32'h0000_0009);
        rd(`GMS_REG_IRQ_STAT, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        press(5);
        wsig(1, 1'b0);
        chk(32'(run), 32'h0000_0001);
        press(6);
        wsig(1, 1'b1);
        press(7);
        wsig(1, 1'b0);
        @(posedge ref_clk);
        on_load <= 1'b1;
        wsig(1, 1'b1);
        @(posedge ref_clk);
        on_load <= 1'b0;
        repeat (50) @(posedge ref_clk);
        #1;
        chk(32'(close), 32'h0000_0001);
        wr(`GMS_REG_IRQ_MASK, 32'h0000_0000);
        @(posedge ref_clk);
        alarms <= 8'h02;
        press(0);
        chk(32'({run, close, mode}), 32'h0000_0000);
        chk(32'(alarm_latch), 32'h0000_0002);
        rd(`GMS_REG_ALARM, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        press(3);
        chk(32'(run), 32'h0000_0000);
        press(2);
        chk(32'(mode), 32'h0000_0002);
        // Each local request bit, then the link request
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            slow <= i[0];
            if (i < 4) req[i] <= 1'b1;
            else link_req <= 1'b1;
            wsig(1, 1'b1);
            @(posedge ref_clk);
            req <= 4'h0;
            link_req <= 1'b0;
            repeat (500) @(posedge ref_clk);
            #1;
            chk(32'(close), 32'h0000_0001);
            wsig(1, 1'b0);
            chk(32'(run), 32'h0000_0001);
            wsig(0, 1'b0);
        end
        // Software stop through the control register while on load
        @(posedge ref_clk);
        req[0] <= 1'b1;
        wsig(1, 1'b1);
        wr(`GMS_REG_CTRL, 32'h0000_0001);
        #1;
        chk(32'({run, close, mode}), 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire
